// >>> src/scg_defines.vh
// Purpose: constants for the sleep-mode peripheral clock gate bank two
// Assumes: 32-bit register port, byte addresses
// Notes:   included by every design file of the block
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH

`define SCG_ADDR_W          12
`define SCG_DATA_W          32
`define SCG_OFS_RUN_GATE    12'h108
`define SCG_OFS_SLEEP_GATE  12'h118
`define SCG_OFS_DEEP_GATE   12'h128
`define SCG_OFS_CONFIG      12'h060
`define SCG_OFS_STATUS      12'h1F0
`define SCG_OFS_FAULT_CNT   12'h1F4
`define SCG_GATE_MASK       32'h0001_20FF
`define SCG_RESET_VAL       32'h0000_0000
`define SCG_BIT_SERIAL_BUS  16
`define SCG_BIT_MICRO_DMA   13
`define SCG_PORT_LSB        0
`define SCG_PORT_MSB        7
`define SCG_UNITS           10
`define SCG_CFG_AUTO_BIT    27
`define SCG_MODE_W          2
`define SCG_MODE_RUN        2'h0
`define SCG_MODE_SLEEP      2'h1
`define SCG_MODE_DEEP       2'h2
`define SCG_CNT_W           16

`endif

// >>> src/scg_fault_check.v
// Purpose: flags a bus access that targets a unit whose clock is off
// Assumes: unit select is one-hot, or all zero for no access
// Notes:   registered, so the fault stands one cycle after the access
`timescale 1ns/1ps
`include "scg_defines.vh"

module scg_fault_check #(
	parameter UNITS = `SCG_UNITS
) (
	input  wire             clk_sys_i,
	input  wire             rst_i,
	input  wire             ce_i,
	input  wire             access_i,
	input  wire [UNITS-1:0] unit_sel_i,
	input  wire [UNITS-1:0] unit_en_i,
	output reg              fault_o
);

	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			fault_o <= 1'b0;
		else if (ce_i)
			fault_o <= access_i && ((unit_sel_i & ~unit_en_i) != {UNITS{1'b0}});
	end

endmodule // scg_fault_check

// >>> src/scg_gate_reg.v
// Purpose: one masked clock gate register with software access
// Assumes: writes are single-cycle strobes on the system clock
// Notes:   unimplemented bits are never stored, so they read as zero
`timescale 1ns/1ps
`include "scg_defines.vh"

module scg_gate_reg #(
	parameter [31:0] MASK  = `SCG_GATE_MASK,
	parameter [31:0] RESET = `SCG_RESET_VAL
) (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        ce_i,
	input  wire        wr_i,
	input  wire [31:0] wdata_i,
	output reg  [31:0] value_o
);

	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			value_o <= RESET;
		else if (ce_i && wr_i)
			value_o <= wdata_i & MASK;
	end

endmodule // scg_gate_reg

// >>> src/scg_sleep_gate.v
// Purpose: system-control gate bank two with mode selection and fault flag
// Assumes: power mode comes from same-clock logic; unit access select too
// Notes:   clock enables are levels for downstream glitch-free gating cells
`timescale 1ns/1ps
`include "scg_defines.vh"

module scg_sleep_gate #(
	parameter UNITS = `SCG_UNITS
) (
	input  wire                    clk_sys_i,
	input  wire                    rst_i,
	input  wire                    ce_i,
	input  wire [`SCG_ADDR_W-1:0]  addr_i,
	input  wire [`SCG_DATA_W-1:0]  wdata_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	output reg  [`SCG_DATA_W-1:0]  rdata_o,
	input  wire [`SCG_MODE_W-1:0]  power_mode_i,
	input  wire                    unit_access_i,
	input  wire [UNITS-1:0]        unit_sel_i,
	output reg  [UNITS-1:0]        unit_clk_en_o,
	output wire                    bus_fault_o
);

	localparam ST_RUN   = 3'b001;
	localparam ST_SLEEP = 3'b010;
	localparam ST_DEEP  = 3'b100;

	reg  [2:0]             state;
	reg  [2:0]             next_state;
	reg  [31:0]            run_clock_configuration;
	reg  [`SCG_CNT_W-1:0]  fault_count;
	reg  [UNITS-1:0]       next_unit_clk_en;
	reg  [31:0]            next_rdata;
	wire [31:0]            run_peripheral_clock_gate_two;
	wire [31:0]            sleep_peripheral_clock_gate_two;
	wire [31:0]            deep_sleep_peripheral_clock_gate_two;
	wire                   auto_gating_select;
	wire                   fault;

	// Packs the ten implemented gate bits into one unit vector
	function [UNITS-1:0] gate_units;
		input [31:0] r;
		begin
			gate_units = {r[`SCG_BIT_SERIAL_BUS],
				r[`SCG_BIT_MICRO_DMA],
				r[`SCG_PORT_MSB:`SCG_PORT_LSB]};
		end
	endfunction

	function sel_wr;
		input [`SCG_ADDR_W-1:0] a;
		input [`SCG_ADDR_W-1:0] ofs;
		begin
			sel_wr = wr_i && (a == ofs);
		end
	endfunction

	assign auto_gating_select = run_clock_configuration[`SCG_CFG_AUTO_BIT];

	scg_gate_reg u_run_gate (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.wr_i      (sel_wr(addr_i, `SCG_OFS_RUN_GATE)),
		.wdata_i   (wdata_i),
		.value_o   (run_peripheral_clock_gate_two)
	);

	scg_gate_reg u_sleep_gate (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.wr_i      (sel_wr(addr_i, `SCG_OFS_SLEEP_GATE)),
		.wdata_i   (wdata_i),
		.value_o   (sleep_peripheral_clock_gate_two)
	);

	scg_gate_reg u_deep_gate (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.wr_i      (sel_wr(addr_i, `SCG_OFS_DEEP_GATE)),
		.wdata_i   (wdata_i),
		.value_o   (deep_sleep_peripheral_clock_gate_two)
	);

	// Only the auto gating select bit is kept; other bits belong elsewhere
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			run_clock_configuration <= `SCG_RESET_VAL;
		else if (ce_i && sel_wr(addr_i, `SCG_OFS_CONFIG))
			run_clock_configuration <= wdata_i & (32'h0000_0001 << `SCG_CFG_AUTO_BIT);
	end

	// Without auto gating the low-power modes keep using run gates
	always @*
	begin
		next_state = ST_RUN;
		if (auto_gating_select)
		begin
			case (power_mode_i)
				`SCG_MODE_SLEEP: next_state = ST_SLEEP;
				`SCG_MODE_DEEP:  next_state = ST_DEEP;
				default:         next_state = ST_RUN;
			endcase
		end
	end

	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			state <= ST_RUN;
		else if (ce_i)
			state <= next_state;
	end

	// A clear bit drops the enable, a set bit raises it
	always @*
	begin
		case (state)
			ST_SLEEP: next_unit_clk_en = gate_units(sleep_peripheral_clock_gate_two);
			ST_DEEP:  next_unit_clk_en = gate_units(deep_sleep_peripheral_clock_gate_two);
			ST_RUN:   next_unit_clk_en = gate_units(run_peripheral_clock_gate_two);
			default:  next_unit_clk_en = gate_units(run_peripheral_clock_gate_two);
		endcase
	end

	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			unit_clk_en_o <= {UNITS{1'b0}};
		else if (ce_i)
			unit_clk_en_o <= next_unit_clk_en;
	end

	// Checked against registered enables so fault and clock agree in time
	scg_fault_check #(
		.UNITS (UNITS)
	) u_fault (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.access_i   (unit_access_i),
		.unit_sel_i (unit_sel_i),
		.unit_en_i  (unit_clk_en_o),
		.fault_o    (fault)
	);

	assign bus_fault_o = fault;

	// Counter saturates rather than wraps so software never sees a false zero
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			fault_count <= {`SCG_CNT_W{1'b0}};
		else if (ce_i && sel_wr(addr_i, `SCG_OFS_FAULT_CNT))
			fault_count <= {`SCG_CNT_W{1'b0}};
		else if (ce_i && fault && (fault_count != {`SCG_CNT_W{1'b1}}))
			fault_count <= fault_count + 1'b1;
	end

	always @*
	begin
		case (addr_i)
			`SCG_OFS_RUN_GATE:   next_rdata = run_peripheral_clock_gate_two;
			`SCG_OFS_SLEEP_GATE: next_rdata = sleep_peripheral_clock_gate_two;
			`SCG_OFS_DEEP_GATE:  next_rdata = deep_sleep_peripheral_clock_gate_two;
			`SCG_OFS_CONFIG:     next_rdata = run_clock_configuration;
			`SCG_OFS_STATUS:     next_rdata = {{(32-UNITS-3){1'b0}}, state, unit_clk_en_o};
			`SCG_OFS_FAULT_CNT:  next_rdata = {{(32-`SCG_CNT_W){1'b0}}, fault_count};
			default:             next_rdata = `SCG_RESET_VAL;
		endcase
	end

	// Read data stand only in the cycle after the read strobe
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			rdata_o <= `SCG_RESET_VAL;
		else if (ce_i)
			rdata_o <= rd_i ? next_rdata : `SCG_RESET_VAL;
	end

endmodule // scg_sleep_gate

// >>> test/scg_sleep_gate_bench.sv
// Purpose: directed bench for the sleep clock gate bank two
// Assumes: ce_i held high; enables settle two edges after a gate write or mode change, three after a config write
// Notes:   gaps between transfers keep each strobe to one assignment a step
`timescale 1ns/1ps
`include "scg_defines.vh"
module scg_sleep_gate_bench;
	reg          clk_sys_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, unit_access_i = 0;
	reg  [11:0]  addr_i = 12'h000;
	reg  [31:0]  wdata_i = 32'h0;
	reg  [1:0]   power_mode_i = 2'h0;
	reg  [9:0]   unit_sel_i = 10'h000;
	wire [31:0]  rdata_o;
	wire [9:0]   unit_clk_en_o;
	wire         bus_fault_o;
	integer      miscompares = 0, checks = 0, cycles = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	scg_sleep_gate i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.power_mode_i(power_mode_i), .unit_access_i(unit_access_i), .unit_sel_i(unit_sel_i),
		.unit_clk_en_o(unit_clk_en_o), .bus_fault_o(bus_fault_o));
	task final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [11:0] a, input [31:0] e);
		@(posedge clk_sys_i);
		rd_i <= 1'b1; addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 cmp(rdata_o, e);
	endtask
	task en(input [9:0] e);
		repeat (3) @(posedge clk_sys_i);
		#1 cmp({22'h0, unit_clk_en_o}, {22'h0, e});
	endtask
	task acc(input [9:0] sel, input f);
		@(posedge clk_sys_i);
		unit_access_i <= 1'b1; unit_sel_i <= sel;
		@(posedge clk_sys_i);
		unit_access_i <= 1'b0;
		#1 cmp({31'h0, bus_fault_o}, {31'h0, f});
	endtask
	always @(posedge clk_sys_i)
	begin
		cycles = cycles + 1;
		// Whole run is near 57 cycles, so this only cuts a hang
		if (cycles == 2000)
		begin
			miscompares = miscompares + 1;
			final_report;
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(`SCG_OFS_SLEEP_GATE, 32'h0);
		en(10'h000);
		wr(`SCG_OFS_SLEEP_GATE, 32'hFFFF_FFFF);
		rd(`SCG_OFS_SLEEP_GATE, 32'h0001_20FF);
		rd(12'h004, 32'h0);
		wr(`SCG_OFS_RUN_GATE, 32'h0000_0001);
		wr(`SCG_OFS_SLEEP_GATE, 32'h0001_2082);
		@(posedge clk_sys_i) power_mode_i <= `SCG_MODE_SLEEP;
		en(10'h001);
		wr(`SCG_OFS_CONFIG, 32'h0800_0000);
		en(10'h382);
		acc(10'h002, 1'b0);
		acc(10'h001, 1'b1);
		rd(`SCG_OFS_FAULT_CNT, 32'h0000_0001);
		@(posedge clk_sys_i) power_mode_i <= `SCG_MODE_DEEP;
		en(10'h000);
		@(posedge clk_sys_i) power_mode_i <= `SCG_MODE_RUN;
		en(10'h001);
		@(posedge clk_sys_i) power_mode_i <= 2'h3;
		en(10'h001);
		@(posedge clk_sys_i) power_mode_i <= `SCG_MODE_RUN;
		wr(`SCG_OFS_SLEEP_GATE, 32'h0);
		en(10'h001);
		@(posedge clk_sys_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		en(10'h000);
		final_report;
	end
endmodule // scg_sleep_gate_bench

// >>> test/scg_sleep_gate_props.sv
// Purpose: port checks for the sleep clock gate bank two
// Assumes: one clock domain, synchronous reset
// Notes:   the reset check overrides the default disable so it can be seen
`timescale 1ns/1ps
`include "scg_defines.vh"
module scg_sleep_gate_props #(
	parameter UNITS = `SCG_UNITS
) (
	input wire                   clk_sys_i,
	input wire                   rst_i,
	input wire                   ce_i,
	input wire [`SCG_ADDR_W-1:0] addr_i,
	input wire [`SCG_DATA_W-1:0] wdata_i,
	input wire                   wr_i,
	input wire                   rd_i,
	input wire [`SCG_DATA_W-1:0] rdata_o,
	input wire [`SCG_MODE_W-1:0] power_mode_i,
	input wire                   unit_access_i,
	input wire [UNITS-1:0]       unit_sel_i,
	input wire [UNITS-1:0]       unit_clk_en_o,
	input wire                   bus_fault_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence sleep_wr_s;
		ce_i && wr_i && addr_i == `SCG_OFS_SLEEP_GATE;
	endsequence
	sequence sleep_rd_s;
		ce_i && rd_i && addr_i == `SCG_OFS_SLEEP_GATE;
	endsequence
	// Enables may only move after a write or a mode change reaches state
	sequence quiet_s;
		ce_i && !wr_i && $stable(power_mode_i);
	endsequence
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
		unit_clk_en_o == 0 && rdata_o == 0 && !bus_fault_o) else $error("reset left outputs set");
	rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 0)
		else $error("read data outside read slot");
	reserved_zero_a: assert property (sleep_rd_s |=> (rdata_o & ~`SCG_GATE_MASK) == 0)
		else $error("reserved bits read nonzero");
	read_back_a: assert property (sleep_wr_s ##1 ce_i && !wr_i ##1 sleep_rd_s |=>
		rdata_o == ($past(wdata_i, 3) & `SCG_GATE_MASK)) else $error("gate read back wrong");
	fault_pulse_a: assert property (ce_i && unit_access_i && unit_sel_i != 0 &&
		(unit_sel_i & unit_clk_en_o) == 0 |=> bus_fault_o) else $error("missing bus fault");
	no_fault_a: assert property (ce_i && !unit_access_i |=> !bus_fault_o)
		else $error("bus fault without access");
	en_stable_a: assert property (quiet_s ##1 quiet_s ##1 quiet_s |=> $stable(unit_clk_en_o))
		else $error("enables moved without cause");
	run_inert_a: assert property ((sleep_wr_s and (power_mode_i == `SCG_MODE_RUN &&
		$past(power_mode_i) == `SCG_MODE_RUN && !$past(wr_i))) ##1 (ce_i && !wr_i)
		|=> $stable(unit_clk_en_o)) else $error("sleep gate acted in run");
endmodule // scg_sleep_gate_props

bind scg_sleep_gate scg_sleep_gate_props #(.UNITS(UNITS)) i_props (.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .power_mode_i(power_mode_i), .unit_access_i(unit_access_i),
	.unit_sel_i(unit_sel_i), .unit_clk_en_o(unit_clk_en_o), .bus_fault_o(bus_fault_o));
